// ### rtl/acts_core.sv
`timescale 1ns/1ps

// Overview of operation
// - Stay in partial power-down when idle, including after supply power-up.
// - Fully power up before each conversion; drop back automatically afterwards.
// - Command mode: host write-address phase wakes and triggers a conversion.
// - Command mode: read start wakes device, conversion completes during address.
// - Autocycle mode: convert every 50 us without host help.
// - Serial reads and writes are serviced during partial power-down.
// - Voltage results straight binary, LSB reference/4096; temperature two's complement.
// - Finished temperature integration starts a temperature conversion automatically.
// - Running command voltage conversion finishes before a due temperature conversion.
// - Without voltage conversions, temperature converts every 5 ms.
// - Autocycle: temperature slotted into sequence; starts at once if idle.
// - Temperature result register holds latest result, always readable.
// - Temperature sensing and averaging run only while enable bit is set.
// - Average becomes seven eighths old plus one eighth new.
// - First result after enable is genuine and stays until overwritten.
// - Temperature stored as 12-bit two's complement, 0.25 degree LSB.
// - Reference select bit picks internal or outside reference; internal after reset.
// - Short low reset pulse restores command and sequencer registers to defaults on the next clock edge.
// - Reset pin held low beyond 100 ns enters full power-down.
// - Command register 16 bits, write-only, zero default, two bytes MSB first.
module acts_core
    import acts_pkg::*;
#(
    parameter int AUTO_CYCLES  = AUTO_CYC,
    parameter int TEMP_CYCLES  = TEMP_CYC,
    parameter int CONV_CYCLES  = 16,
    parameter int WAKE_CYCLES  = 4
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Power-down/reset pin, synchronous sample
    input  wire logic              powerdown_reset_n,
    // Serial-side events
    input  wire logic              write_addr_seen,
    input  wire logic              read_start,
    input  wire logic              cmd_byte_valid,
    input  wire logic [7:0]        cmd_byte,
    // Analog core
    input  wire logic              integ_done,
    input  wire logic              sar_done,
    input  wire logic [RES_W-1:0]  sar_code,
    output logic                   full_power,
    output logic                   full_powerdown,
    output logic                   sar_start,
    output logic                   sar_temp_sel,
    output logic                   temp_measure_enable,
    output logic                   outside_reference_select,
    // Results
    output logic [RES_W-1:0]       volt_result,
    output logic [RES_W-1:0]       temp_result,
    output logic [RES_W-1:0]       temp_average,
    output logic [CMD_W-1:0]       cmd_value
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // Wake counter is 16 bits and the timers 32 bits wide
    if (CONV_CYCLES < 1 || WAKE_CYCLES < 1 || WAKE_CYCLES > 65536
            || AUTO_CYCLES < 2 || TEMP_CYCLES < 2) begin : g_bad_counts
        $error("acts_core: counts out of range");
    end

    // ------------------------------------------------------------
    // Command register and reset pin
    // ------------------------------------------------------------
    logic [CMD_W-1:0] cmd_r, cmd_nxt;
    logic             half_r, half_nxt;
    logic [7:0]       hi_r, hi_nxt;
    logic [7:0]       pd_cnt_r, pd_cnt_nxt;
    logic             fpd_r, fpd_nxt;
    logic             soft_rst;

    always_comb begin
        cmd_nxt    = cmd_r;
        half_nxt   = half_r;
        hi_nxt     = hi_r;
        pd_cnt_nxt = pd_cnt_r;
        fpd_nxt    = fpd_r;
        if (!powerdown_reset_n) begin
            // Pin sampled on clk, so shortest honoured pulse is one period
            // Saturates, so a long hold never wraps back into a bare reset
            if (pd_cnt_r != 8'hff)
                pd_cnt_nxt = pd_cnt_r + 8'h01;
            if (int'(pd_cnt_r) + 1 > PDRST_CYC)
                fpd_nxt = 1'b1;
        end else begin
            pd_cnt_nxt = 8'h00;
            fpd_nxt    = 1'b0;
        end
        if (cmd_byte_valid) begin
            if (!half_r) begin
                hi_nxt   = cmd_byte;
                half_nxt = 1'b1;
            end else begin
                cmd_nxt  = {hi_r, cmd_byte};
                half_nxt = 1'b0;
            end
        end
        // Odd byte is dropped by a new write address
        if (write_addr_seen)
            half_nxt = 1'b0;
    end

    // Pin is sampled, so the restore lands on the next edge
    assign soft_rst = !powerdown_reset_n;

    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst) begin
            cmd_r <= CMD_RESET;
            half_r <= 1'b0;
            hi_r   <= 8'h00;
        end else begin
            cmd_r  <= cmd_nxt;
            half_r <= half_nxt;
            hi_r   <= hi_nxt;
        end
        if (!rst_n) begin
            pd_cnt_r <= 8'h00;
            fpd_r    <= 1'b0;
        end else begin
            pd_cnt_r <= pd_cnt_nxt;
            fpd_r    <= fpd_nxt;
        end
    end

    logic tsen, auto_mode;
    assign tsen      = cmd_r[temp_enable_bit_position];
    assign auto_mode = cmd_r[AUTO_BIT];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    acts_state_t     st_r, st_nxt;
    logic [15:0]     cnt_r, cnt_nxt;
    logic [31:0]     auto_r, auto_nxt;
    logic [31:0]     tmr_r, tmr_nxt;
    logic            vpend_r, vpend_nxt;
    logic            tpend_r, tpend_nxt;
    logic            cur_t_r, cur_t_nxt;
    logic            start_r, start_nxt;
    logic [RES_W-1:0] volt_r, volt_nxt, tres_r, tres_nxt, avg_r, avg_nxt;
    logic            seeded_r, seeded_nxt;
    logic [RES_W+2:0] acc;
    logic            v_set;
    logic            t_set;
    acts_result_t    conv_res;

    // Done outside a conversion is stray and is dropped
    assign conv_res = '{valid:   sar_done && (st_r == ACTS_CONV),
                        is_temp: cur_t_r,
                        code:    sar_code};

    always_comb begin
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        auto_nxt   = auto_r;
        tmr_nxt    = tmr_r;
        vpend_nxt  = vpend_r;
        tpend_nxt  = tpend_r;
        cur_t_nxt  = cur_t_r;
        start_nxt  = 1'b0;
        volt_nxt   = volt_r;
        tres_nxt   = tres_r;
        avg_nxt    = avg_r;
        seeded_nxt = seeded_r;
        acc        = '0;
        v_set      = 1'b0;
        t_set      = 1'b0;
        // Request capture; pending requests survive an active conversion
        if (!auto_mode && (write_addr_seen || read_start))
            v_set = 1'b1;
        // Free-running, so the autocycle grid holds across conversions
        if (auto_mode) begin
            if (auto_r >= 32'(AUTO_CYCLES - 1)) begin
                auto_nxt = 32'h0;
                v_set    = 1'b1;
            end else
                auto_nxt = auto_r + 32'h1;
        end else
            auto_nxt = 32'h0;
        if (tsen) begin
            if (integ_done)
                t_set = 1'b1;
            // Periodic fallback while no voltage traffic
            if (vpend_r || st_r != ACTS_SLEEP)
                tmr_nxt = 32'h0;
            else if (tmr_r >= 32'(TEMP_CYCLES - 1)) begin
                tmr_nxt = 32'h0;
                t_set   = 1'b1;
            end else
                tmr_nxt = tmr_r + 32'h1;
        end else begin
            tpend_nxt  = 1'b0;
            tmr_nxt    = 32'h0;
            seeded_nxt = 1'b0;
        end
        case (st_r)
            ACTS_SLEEP: begin
                if (vpend_r || tpend_r) begin
                    st_nxt  = ACTS_WAKE;
                    cnt_nxt = 16'h0;
                end
            end
            ACTS_WAKE: begin
                if (cnt_r >= 16'(WAKE_CYCLES - 1)) begin
                    st_nxt    = ACTS_CONV;
                    start_nxt = 1'b1;
                    // Temperature takes the next slot, voltage waits
                    cur_t_nxt = tpend_r;
                    if (tpend_r)
                        tpend_nxt = 1'b0;
                    else
                        vpend_nxt = 1'b0;
                end else
                    cnt_nxt = cnt_r + 16'h1;
            end
            ACTS_CONV: begin
                if (conv_res.valid) begin
                    st_nxt = ACTS_SLEEP;
                    if (conv_res.is_temp) begin
                        tres_nxt = conv_res.code;
                        if (!seeded_r) begin
                            avg_nxt    = conv_res.code;
                            seeded_nxt = 1'b1;
                        end else begin
                            // Three guard bits keep seven times the average from overflowing
                            acc     = {avg_r[RES_W-1], avg_r[RES_W-1], avg_r[RES_W-1], avg_r}
                                    * 15'(7)
                                    + {{3{conv_res.code[RES_W-1]}}, conv_res.code};
                            avg_nxt = RES_W'($signed(acc) >>> 3);
                        end
                    end else
                        volt_nxt = conv_res.code;
                end
            end
            default: st_nxt = ACTS_SLEEP;
        endcase
        // New request on the consuming edge wins, so none is lost
        if (v_set)
            vpend_nxt = 1'b1;
        if (t_set)
            tpend_nxt = 1'b1;
        // Full power-down overrides any pending work
        if (fpd_r)
            st_nxt = ACTS_SLEEP;
    end

    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst) begin
            st_r     <= ACTS_SLEEP;
            cnt_r    <= 16'h0;
            auto_r   <= 32'h0;
            tmr_r    <= 32'h0;
            vpend_r  <= 1'b0;
            tpend_r  <= 1'b0;
            cur_t_r  <= 1'b0;
            start_r  <= 1'b0;
            volt_r   <= '0;
            tres_r   <= '0;
            avg_r    <= '0;
            seeded_r <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            auto_r   <= auto_nxt;
            tmr_r    <= tmr_nxt;
            vpend_r  <= vpend_nxt;
            tpend_r  <= tpend_nxt;
            cur_t_r  <= cur_t_nxt;
            start_r  <= start_nxt;
            volt_r   <= volt_nxt;
            tres_r   <= tres_nxt;
            avg_r    <= avg_nxt;
            seeded_r <= seeded_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Serial side is independent of state, so access works asleep
    assign full_power               = (st_r != ACTS_SLEEP);
    assign full_powerdown           = fpd_r;
    assign sar_start                = start_r;
    assign sar_temp_sel             = cur_t_r;
    // Sensor held off in full power-down
    assign temp_measure_enable      = tsen && !fpd_r;
    // Zero after reset selects the internal reference
    assign outside_reference_select = cmd_r[OUTREF_BIT];
    assign volt_result              = volt_r;
    assign temp_result              = tres_r;
    assign temp_average             = avg_r;
    assign cmd_value                = cmd_r;

endmodule : acts_core

// ### shared/acts_pkg.sv
package acts_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 40_000_000;
    localparam int AUTO_PERIOD_US  = 50;
    localparam int TEMP_PERIOD_US  = 5000;
    localparam int PDRST_MAX_NS    = 100;
    localparam int CLK_PERIOD_NS   = 25;
    localparam int AUTO_CYC        = CLK_HZ / 1_000_000 * AUTO_PERIOD_US;
    localparam int TEMP_CYC        = CLK_HZ / 1_000_000 * TEMP_PERIOD_US;
    localparam int PDRST_CYC       = (PDRST_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Command register layout
    // ------------------------------------------------------------
    localparam int             CMD_W                    = 16;
    localparam logic [15:0]    CMD_RESET                = 16'h0000;
    localparam int             temp_enable_bit_position = 7;
    localparam int             OUTREF_BIT               = 4;
    localparam int             AUTO_BIT                 = 2;
    localparam int             RES_W                    = 12;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACTS_SLEEP = 2'b00,
        ACTS_WAKE  = 2'b01,
        ACTS_CONV  = 2'b11
    } acts_state_t;

    typedef struct packed {
        logic             valid;
        logic             is_temp;
        logic [RES_W-1:0] code;
    } acts_result_t;

endpackage : acts_pkg

// ### verif/acts_core_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// Sequencer port checker
// ----------------------------------------
module acts_core_monitor
    import acts_pkg::*;
(
    // Clock and reset
    input wire logic             clk,
    input wire logic             rst_n,
    // Pin and serial events
    input wire logic             powerdown_reset_n,
    input wire logic             write_addr_seen,
    input wire logic             read_start,
    // Converter side
    input wire logic             sar_done,
    input wire logic [RES_W-1:0] sar_code,
    input wire logic             full_power,
    input wire logic             full_powerdown,
    input wire logic             sar_start,
    input wire logic             sar_temp_sel,
    input wire logic             temp_measure_enable,
    input wire logic             outside_reference_select,
    input wire logic [RES_W-1:0] volt_result,
    input wire logic [RES_W-1:0] temp_result,
    input wire logic [CMD_W-1:0] cmd_value
);
    default clocking @(posedge clk); endclocking
    // Pin low clears the sequencer, so timing checks pause
    default disable iff (!rst_n || !powerdown_reset_n);

    property p_wake; $rose(full_power) |-> !sar_start [*4] ##1 sar_start; endproperty
    a_wake: assert property (p_wake) else $error("wake length wrong");
    property p_drop; $fell(full_power) |-> $past(sar_done); endproperty
    a_drop: assert property (p_drop) else $error("power dropped early");
    property p_trig;
        (write_addr_seen || read_start) && !cmd_value[AUTO_BIT] |-> ##[1:4] full_power;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger ignored");
    property p_auto; cmd_value[AUTO_BIT] && !full_power |-> ##[1:24] full_power; endproperty
    a_auto: assert property (p_auto) else $error("autocycle late");
    property p_volt;
        sar_done && full_power && !sar_temp_sel |=> volt_result == $past(sar_code);
    endproperty
    a_volt: assert property (p_volt) else $error("voltage result wrong");
    property p_temp;
        sar_done && full_power && sar_temp_sel |=> temp_result == $past(sar_code);
    endproperty
    a_temp: assert property (p_temp) else $error("temperature result wrong");
    property p_sel; sar_start && !temp_measure_enable |-> !sar_temp_sel; endproperty
    a_sel: assert property (p_sel) else $error("temperature while disabled");
    property p_en;
        temp_measure_enable == cmd_value[temp_enable_bit_position]
            && outside_reference_select == cmd_value[OUTREF_BIT];
    endproperty
    a_en: assert property (p_en) else $error("control bits wrong");
    property p_pdclr; disable iff (!rst_n) !powerdown_reset_n |=> cmd_value == 16'h0000; endproperty
    a_pdclr: assert property (p_pdclr) else $error("command not cleared");
    property p_pdlong; disable iff (!rst_n) !powerdown_reset_n [*6] |=> full_powerdown; endproperty
    a_pdlong: assert property (p_pdlong) else $error("no full power-down");

    c_temp: cover property (sar_start && sar_temp_sel);
    c_auto: cover property (sar_start && cmd_value[AUTO_BIT]);
    c_pd: cover property (disable iff (!rst_n) $rose(full_powerdown));
endmodule : acts_core_monitor

// ### verif/acts_sar_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Converter core stand-in
// ----------------------------------------
module acts_sar_model
    import acts_pkg::*;
(
    // Request
    input wire logic             clk,
    input wire logic [3:0]       lat,
    input wire logic [RES_W-1:0] code_in,
    input wire logic             sar_start,
    // Answer
    output logic                 sar_done = 1'b0,
    output logic [RES_W-1:0]     sar_code = 12'h000
);
    // Code inverted outside done, so a stale capture never matches
    always @(posedge clk) begin
        if (sar_start === 1'b1) begin
            repeat (lat) @(posedge clk);
            sar_code <= code_in;
            sar_done <= 1'b1;
            @(posedge clk);
            sar_done <= 1'b0;
            sar_code <= ~code_in;
        end
    end
endmodule : acts_sar_model

// ### verif/acts_core_tb.sv
`timescale 1ns/1ps
module acts_core_tb
    import acts_pkg::*;
;
    logic             clk = 1'b0, rst_n = 1'b0, pd_n = 1'b1;
    logic             wa = 1'b0, rs = 1'b0, cv = 1'b0, ig = 1'b0;
    logic [7:0]       cb = 8'h00;
    logic             sdone, fp, fpd, sst, tsel, ten, oref;
    logic [RES_W-1:0] scode, vres, tres, tavg, pcode = 12'h000;
    logic [CMD_W-1:0] cmdv;
    logic [3:0]       lat = 4'h1;
    logic [15:0]      lf = 16'h0024;
    int               n_fail = 0, n_checks = 0, m_avg = 0;
    bit               m_seed = 1'b0;

    always #12.5 clk = ~clk;

    acts_core #(.AUTO_CYCLES(20), .TEMP_CYCLES(50), .WAKE_CYCLES(4)) u_dut (
        .clk(clk), .rst_n(rst_n), .powerdown_reset_n(pd_n), .write_addr_seen(wa),
        .read_start(rs), .cmd_byte_valid(cv), .cmd_byte(cb), .integ_done(ig),
        .sar_done(sdone), .sar_code(scode), .full_power(fp), .full_powerdown(fpd),
        .sar_start(sst), .sar_temp_sel(tsel), .temp_measure_enable(ten),
        .outside_reference_select(oref), .volt_result(vres), .temp_result(tres),
        .temp_average(tavg), .cmd_value(cmdv));
    acts_sar_model u_sar (.clk(clk), .lat(lat), .code_in(pcode), .sar_start(sst),
        .sar_done(sdone), .sar_code(scode));

    // ----------------------------------------
    // Reference average, seeded on first result
    // ----------------------------------------
    always @(posedge clk) begin
        if (sdone === 1'b1 && tsel === 1'b1) begin
            m_avg <= m_seed ? (7 * m_avg + int'($signed(scode))) >>> 3 : int'($signed(scode));
            m_seed <= 1'b1;
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wt(input bit on_done);
        int k;
        for (k = 0; k < 400 && (on_done ? sdone : sst) !== 1'b1; k++) @(negedge clk);
        if (k == 400) begin
            chk(16'h0000, 16'h0001);
            wrap_up();
        end
    endtask : wt

    task automatic ev(input int k);
        @(negedge clk);
        {ig, rs, wa} = 3'b001 << k;
        @(negedge clk);
        {ig, rs, wa} = 3'b000;
    endtask : ev

    task automatic wcmd(input logic [15:0] v);
        @(negedge clk);
        cv = 1'b1;
        cb = v[15:8];
        @(negedge clk);
        cb = v[7:0];
        @(negedge clk);
        cv = 1'b0;
        if (!v[7]) m_seed = 1'b0;
        @(negedge clk);
        chk(cmdv, v);
    endtask : wcmd

    // Random code and random converter latency, so slow and prompt answers both occur
    task automatic run(input logic t, input bit ti);
        lf = lfsr(lf);
        pcode = lf[11:0];
        lat = {2'b00, lf[13:12]} + 4'h1;
        wt(1'b0);
        chk(tsel, t);
        if (ti) ev(2);
        wt(1'b1);
        @(negedge clk);
        if (t) begin
            chk(tres, pcode);
            chk(tavg, m_avg[11:0]);
        end else
            chk(vres, pcode);
    endtask : run

    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(fp, 1'b0);
        chk(oref, 1'b0);
        chk(cmdv, 16'h0000);
        // Outside reference kept for all conversions, so no buffer start-up wait
        wcmd(16'h0010);
        chk(oref, 1'b1);
        for (int i = 0; i < 4; i++) begin
            if (i == 0) begin
                // Lone byte, dropped by the write address below
                @(negedge clk);
                cv = 1'b1;
                cb = 8'hff;
                @(negedge clk);
                cv = 1'b0;
            end
            ev(i % 2);
            run(1'b0, 1'b0);
        end
        $display("command mode test done");
        wcmd(16'h0090);
        chk(ten, 1'b1);
        run(1'b1, 1'b0);
        run(1'b1, 1'b0);
        ev(0);
        run(1'b0, 1'b1);
        run(1'b1, 1'b0);
        ev(2);
        run(1'b1, 1'b0);
        $display("temperature test done");
        wcmd(16'h0014);
        run(1'b0, 1'b0);
        run(1'b0, 1'b0);
        $display("autocycle test done");
        for (int i = 2; i <= 8; i += 6) begin
            pd_n = 1'b0;
            repeat (i) @(negedge clk);
            chk(fpd, i > 2);
            pd_n = 1'b1;
            @(negedge clk);
            chk(cmdv, 16'h0000);
        end
        $display("power-down test done");
        wrap_up();
    end
endmodule : acts_core_tb

bind acts_core acts_core_monitor u_mon (.clk(clk), .rst_n(rst_n),
    .powerdown_reset_n(powerdown_reset_n), .write_addr_seen(write_addr_seen),
    .read_start(read_start), .sar_done(sar_done), .sar_code(sar_code),
    .full_power(full_power), .full_powerdown(full_powerdown), .sar_start(sar_start),
    .sar_temp_sel(sar_temp_sel), .temp_measure_enable(temp_measure_enable),
    .outside_reference_select(outside_reference_select), .volt_result(volt_result),
    .temp_result(temp_result), .cmd_value(cmd_value));
